// ---- ddcdc_pkg.sv ----
`default_nettype none
package ddcdc_pkg;
  // ***********************************
  // widths
  // ***********************************
  localparam int IN_W       = 15;
  localparam int LANE_W     = 17;
  localparam int ACC_W      = 48;
  localparam int OUT_W      = 15;
  localparam int REAL_W     = 12;
  localparam int WORD_W     = 16;
  localparam int IN_SHL     = LANE_W - IN_W;
  localparam int REAL_PAD   = WORD_W - REAL_W;
  localparam int NSTG       = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = 2 * WORD_W;
  localparam int GAP_W      = 6;
  // ***********************************
  // coefficient halves, center tap last
  // ***********************************
  localparam int HB1_NH = 4;
  localparam int HB1_SH = 5;
  localparam int HB1_COEF [HB1_NH] = '{-1, 0, 9, 16};
  localparam int HB2_NH = 4;
  localparam int HB2_SH = 11;
  localparam int HB2_COEF [HB2_NH] = '{-65, 0, 577, 1024};
  localparam int HB3_NH = 6;
  localparam int HB3_SH = 14;
  localparam int HB3_COEF [HB3_NH] = '{109, 0, -837, 0, 4824, 8192};
  localparam int HB4_NH = 8;
  localparam int HB4_SH = 17;
  localparam int HB4_COEF [HB4_NH] = '{-327, 0, 2231, 0, -8881, 0, 39742, 65536};
  localparam int HB5_NH = 28;
  localparam int HB5_SH = 19;
  localparam int HB5_COEF [HB5_NH] = '{-37, 0, 118, 0, -291, 0, 612, 0, -1159, 0,
    2031, 0, -3356, 0, 5308, 0, -8140, 0, 12284, 0, -18628, 0, 29455, 0, -53191, 0,
    166059, 262144};
  // ***********************************
  // registers
  // ***********************************
  localparam int ADDR_W         = 12;
  localparam int MODE_W         = 5;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_BOOST_BIT = 8;
  localparam int STAT_DEC_LSB   = 0;
  localparam int STAT_CNT_LSB   = 4;
  localparam int STAT_FULL_BIT  = 9;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [MODE_W-1:0] MODE_RST    = 5'h00;
  localparam logic [MODE_W-1:0] MODE_BYPASS = 5'h00;
  localparam logic [MODE_W-1:0] MODE_DEC4   = 5'h01;
  localparam logic [MODE_W-1:0] MODE_DEC8   = 5'h02;
  localparam logic [MODE_W-1:0] MODE_DEC16  = 5'h03;
  localparam logic [MODE_W-1:0] MODE_DEC32  = 5'h04;
  // ***********************************
  // types
  // ***********************************
  typedef enum logic [2:0] {DEC_BYPASS, DEC_4, DEC_8, DEC_16, DEC_32} ddcdc_dec_e;
  typedef struct packed {
    logic signed [IN_W-1:0] i;
    logic signed [IN_W-1:0] q;
  } ddcdc_mix_s;
  typedef struct packed {
    logic signed [LANE_W-1:0] i;
    logic signed [LANE_W-1:0] q;
  } ddcdc_lane_s;
  typedef struct packed {
    logic [WORD_W-1:0] i_w;
    logic [WORD_W-1:0] q_w;
  } ddcdc_word_s;
  // ***********************************
  // functions
  // ***********************************
  function automatic ddcdc_dec_e mode_to_dec(input logic [MODE_W-1:0] m);
    case (m)
      MODE_DEC4:  return DEC_4;
      MODE_DEC8:  return DEC_8;
      MODE_DEC16: return DEC_16;
      MODE_DEC32: return DEC_32;
      default:    return DEC_BYPASS;
    endcase
  endfunction : mode_to_dec
  function automatic int dec_first(input ddcdc_dec_e d);
    case (d)
      DEC_32:  return 0;
      DEC_16:  return 1;
      DEC_8:   return 2;
      DEC_4:   return 3;
      default: return NSTG;
    endcase
  endfunction : dec_first
  function automatic int dec_factor(input ddcdc_dec_e d);
    return 1 << (NSTG - dec_first(d));
  endfunction : dec_factor
  function automatic logic signed [ACC_W-1:0] sat(input logic signed [ACC_W-1:0] v,
                                                  input int w);
    logic signed [ACC_W-1:0] mx;
    mx = signed'((ACC_W'(1) << (w - 1)) - ACC_W'(1));
    if (v > mx) return mx;
    if (v < ~mx) return ~mx;
    return v;
  endfunction : sat
endpackage : ddcdc_pkg
`default_nettype wire

// ---- ddcdc_chain.sv ----
`timescale 1ns/100ps
`default_nettype none

// ***********************************
// sample fifo
// ***********************************
module ddcdc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(DEPTH):0]      count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  assign out_data  = mem_ff[rd_ff];
  assign count     = cnt_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ddcdc_fifo

// ***********************************
// half-band decimate-by-2 stage
// ***********************************
module ddcdc_halfband #(
  parameter int NH         = 4,
  parameter int SH         = 5,
  parameter int COEF [NH]  = '{default: 0}
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   adv,
  input  wire logic                   clr,
  input  wire logic                   in_valid,
  input  wire ddcdc_pkg::ddcdc_lane_s in_data,
  output logic                        out_valid,
  output ddcdc_pkg::ddcdc_lane_s      out_data
);
  import ddcdc_pkg::*;
  localparam int NT = 2 * NH - 1;
  localparam logic signed [ACC_W-1:0] RND = ACC_W'(1) << (SH - 1);
  logic signed [LANE_W-1:0] dl_i_ff [NT-1];
  logic signed [LANE_W-1:0] dl_q_ff [NT-1];
  logic signed [LANE_W-1:0] w_i     [NT];
  logic signed [LANE_W-1:0] w_q     [NT];
  logic signed [ACC_W-1:0]  acc_i;
  logic signed [ACC_W-1:0]  acc_q;
  logic signed [ACC_W-1:0]  si;
  logic signed [ACC_W-1:0]  sq;
  logic                     fire;
  logic                     win_eq;
  logic                     phase_ff;
  logic                     valid_ff;
  ddcdc_lane_s              data_ff;

  assign fire      = adv & in_valid & ~clr;
  assign out_valid = valid_ff;
  assign out_data  = data_ff;

  // window: newest sample first
  always_comb begin
    acc_i  = RND;
    acc_q  = RND;
    win_eq = 1'b1;
    w_i[0] = in_data.i;
    w_q[0] = in_data.q;
    for (int k = 1; k < NT; k++) begin
      w_i[k] = dl_i_ff[k-1];
      w_q[k] = dl_q_ff[k-1];
    end
    for (int k = 0; k < NT; k++) begin
      // one tap table folded about the center
      acc_i  = acc_i + ACC_W'(COEF[(k < NH) ? k : NT - 1 - k]) * ACC_W'(w_i[k]);
      acc_q  = acc_q + ACC_W'(COEF[(k < NH) ? k : NT - 1 - k]) * ACC_W'(w_q[k]);
      win_eq = win_eq & (w_i[k] == w_q[k]);
    end
    si = sat(acc_i >>> SH, LANE_W);
    sq = sat(acc_q >>> SH, LANE_W);
  end

  always_ff @(posedge clk) begin
    if (srst || clr) begin
      dl_i_ff <= '{default: '0};
      dl_q_ff <= '{default: '0};
    end else if (fire) begin
      dl_i_ff[0] <= in_data.i;
      dl_q_ff[0] <= in_data.q;
      for (int k = 1; k < NT - 1; k++) begin
        dl_i_ff[k] <= dl_i_ff[k-1];
        dl_q_ff[k] <= dl_q_ff[k-1];
      end
    end
  end

  // one result per two accepted samples
  always_ff @(posedge clk) begin
    if (srst || clr) begin
      phase_ff <= 1'b0;
      valid_ff <= 1'b0;
      data_ff  <= '0;
    end else if (adv) begin
      valid_ff <= fire & phase_ff;
      if (fire) begin
        phase_ff <= ~phase_ff;
      end
      if (fire && phase_ff) begin
        data_ff.i <= si[LANE_W-1:0];
        data_ff.q <= sq[LANE_W-1:0];
      end
    end
  end

  property p_decim2;
    @(posedge clk) disable iff (srst)
    adv && valid_ff |=> !valid_ff;
  endproperty
  a_decim2: assert property (p_decim2) else $error("stage output not decimated by two");

  property p_iq_match;
    @(posedge clk) disable iff (srst)
    fire && phase_ff && win_eq |=> data_ff.i == data_ff.q;
  endproperty
  a_iq_match: assert property (p_iq_match) else $error("i and q paths differ");
endmodule : ddcdc_halfband

// ***********************************
// decimation chain top
// ***********************************
module ddcdc_chain (
  input  wire logic                           clk,
  input  wire logic                           srst,
  input  wire logic                           ce,
  input  wire logic [ddcdc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           mix_valid,
  input  wire ddcdc_pkg::ddcdc_mix_s          mix_data,
  input  wire logic [ddcdc_pkg::REAL_W-1:0]   real_data,
  input  wire logic                           overrange_flag_first,
  input  wire logic                           overrange_flag_second,
  output logic                                in_ready,
  output logic                                out_valid,
  input  wire logic                           out_ready,
  output ddcdc_pkg::ddcdc_word_s              out_data
);
  import ddcdc_pkg::*;
  logic [MODE_W-1:0]               link_mode_select_ff;
  logic                            boost_ff;
  logic                            got_ff;
  logic [31:0]                     prdata_ff;
  logic [31:0]                     rdval;
  logic [MODE_W-1:0]               wmode;
  ddcdc_dec_e                      dec;
  int                              first;
  logic                            bypass;
  logic                            hit_ctrl;
  logic                            hit_stat;
  logic                            wr_ctrl;
  logic                            clr;
  logic                            room;
  logic                            adv;
  logic                            mix_fire;
  logic                            push;
  ddcdc_word_s                     push_data;
  ddcdc_lane_s                     mix_lane;
  ddcdc_lane_s                     st_in  [NSTG];
  ddcdc_lane_s                     st_out [NSTG];
  ddcdc_lane_s                     s5;
  logic [NSTG-1:0]                 st_iv;
  logic [NSTG-1:0]                 st_ov;
  logic signed [ACC_W-1:0]         o_i;
  logic signed [ACC_W-1:0]         o_q;
  int                              sh;
  logic                            flag1_ff;
  logic                            flag2_ff;
  logic [$clog2(FIFO_DEPTH):0]     fifo_cnt;
  logic [GAP_W-1:0]                gap_ff;

  // ***********************************
  // register bus
  // ***********************************
  assign hit_ctrl = paddr == REG_CTRL;
  assign hit_stat = paddr == REG_STATUS;
  assign pready   = ce & got_ff;
  assign pslverr  = pready & ~(hit_ctrl | hit_stat);
  assign prdata   = prdata_ff;
  assign wr_ctrl  = psel & penable & pwrite & pready & hit_ctrl;
  assign clr      = wr_ctrl & pstrb[0];
  assign wmode    = pwdata[CTRL_MODE_LSB +: MODE_W];

  always_ff @(posedge clk) begin
    if (srst) begin
      link_mode_select_ff <= MODE_RST;
      boost_ff            <= 1'b0;
    end else if (wr_ctrl) begin
      if (pstrb[0]) begin
        link_mode_select_ff <= wmode;
      end
      if (pstrb[1]) begin
        boost_ff <= pwdata[CTRL_BOOST_BIT];
      end
    end
  end

  always_comb begin
    rdval = '0;
    if (hit_ctrl) begin
      rdval[CTRL_MODE_LSB +: MODE_W] = link_mode_select_ff;
      rdval[CTRL_BOOST_BIT]          = boost_ff;
    end
    if (hit_stat) begin
      rdval[STAT_DEC_LSB +: $bits(ddcdc_dec_e)] = dec;
      rdval[STAT_CNT_LSB +: $bits(fifo_cnt)]    = fifo_cnt;
      rdval[STAT_FULL_BIT]                      = ~room;
    end
  end

  // setup cycle captures read data, access cycle answers
  always_ff @(posedge clk) begin
    if (srst) begin
      got_ff    <= 1'b0;
      prdata_ff <= '0;
    end else if (ce) begin
      got_ff    <= psel & ~(penable & got_ff);
      prdata_ff <= (psel && !pwrite) ? rdval : '0;
    end
  end

  // ***********************************
  // stage cascade
  // ***********************************
  assign dec      = mode_to_dec(link_mode_select_ff);
  assign first    = dec_first(dec);
  assign bypass   = dec == DEC_BYPASS;
  assign room     = in_ready;
  assign adv      = ce & room;
  assign mix_fire = adv & mix_valid;
  assign mix_lane = '{i: {mix_data.i, {IN_SHL{1'b0}}}, q: {mix_data.q, {IN_SHL{1'b0}}}};

  for (genvar k = 0; k < NSTG; k++) begin : g_link
    if (k == 0) begin : g_head
      assign st_in[k] = mix_lane;
      assign st_iv[k] = (k == first) & mix_valid;
    end else begin : g_tail
      assign st_in[k] = (k == first) ? mix_lane : st_out[k-1];
      assign st_iv[k] = (k == first) ? mix_valid : ((k > first) & st_ov[k-1]);
    end
    property p_stage_order;
      @(posedge clk) disable iff (srst)
      st_iv[k] |-> k >= first;
    endproperty
    a_stage_order: assert property (p_stage_order) else $error("unused stage fed");
  end

  ddcdc_halfband #(.NH(HB1_NH), .SH(HB1_SH), .COEF(HB1_COEF)) halfband_stage_first (
    .clk(clk), .srst(srst), .adv(adv), .clr(clr), .in_valid(st_iv[0]),
    .in_data(st_in[0]), .out_valid(st_ov[0]), .out_data(st_out[0]));
  ddcdc_halfband #(.NH(HB2_NH), .SH(HB2_SH), .COEF(HB2_COEF)) halfband_stage_second (
    .clk(clk), .srst(srst), .adv(adv), .clr(clr), .in_valid(st_iv[1]),
    .in_data(st_in[1]), .out_valid(st_ov[1]), .out_data(st_out[1]));
  ddcdc_halfband #(.NH(HB3_NH), .SH(HB3_SH), .COEF(HB3_COEF)) halfband_stage_third (
    .clk(clk), .srst(srst), .adv(adv), .clr(clr), .in_valid(st_iv[2]),
    .in_data(st_in[2]), .out_valid(st_ov[2]), .out_data(st_out[2]));
  ddcdc_halfband #(.NH(HB4_NH), .SH(HB4_SH), .COEF(HB4_COEF)) halfband_stage_fourth (
    .clk(clk), .srst(srst), .adv(adv), .clr(clr), .in_valid(st_iv[3]),
    .in_data(st_in[3]), .out_valid(st_ov[3]), .out_data(st_out[3]));
  ddcdc_halfband #(.NH(HB5_NH), .SH(HB5_SH), .COEF(HB5_COEF)) halfband_stage_fifth (
    .clk(clk), .srst(srst), .adv(adv), .clr(clr), .in_valid(st_iv[4]),
    .in_data(st_in[4]), .out_valid(st_ov[4]), .out_data(st_out[4]));

  // ***********************************
  // output packing
  // ***********************************
  assign s5 = st_out[NSTG-1];
  assign sh = boost_ff ? IN_SHL - 1 : IN_SHL;
  assign o_i = sat(ACC_W'(s5.i) >>> sh, OUT_W);
  assign o_q = sat(ACC_W'(s5.q) >>> sh, OUT_W);

  always_comb begin
    push_data = '0;
    if (bypass) begin
      push = mix_fire;
      push_data.i_w = {real_data, {REAL_PAD{1'b0}}};
    end else begin
      push = adv & st_ov[NSTG-1];
      push_data.i_w = {o_i[OUT_W-1:0], flag1_ff};
      push_data.q_w = {o_q[OUT_W-1:0], flag2_ff};
    end
  end

  // flags gathered over one output period, a new flag beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      flag1_ff <= 1'b0;
      flag2_ff <= 1'b0;
    end else if (ce) begin
      flag1_ff <= (flag1_ff & ~push) | (mix_fire & ~bypass & overrange_flag_first);
      flag2_ff <= (flag2_ff & ~push) | (mix_fire & ~bypass & overrange_flag_second);
    end
  end

  ddcdc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .in_valid (push),
    .in_ready (in_ready),
    .in_data  (push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data (out_data),
    .count    (fifo_cnt)
  );

  // cycles since last word or flush, for the rate check
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_ff <= GAP_W'(1);
    end else if (ce) begin
      if (push || clr) begin
        gap_ff <= GAP_W'(1);
      end else if (gap_ff != '1) begin
        gap_ff <= gap_ff + 1'b1;
      end
    end
  end

  // ***********************************
  // checks
  // ***********************************
  sequence s_ctrl_write;
    psel && penable && pwrite && pready && hit_ctrl && pstrb[0];
  endsequence
  property p_mode_follows;
    @(posedge clk) disable iff (srst)
    s_ctrl_write |=> dec == mode_to_dec($past(wmode));
  endproperty
  a_mode_follows: assert property (p_mode_follows) else $error("factor not from mode");

  property p_bypass;
    @(posedge clk) disable iff (srst)
    bypass && mix_valid && adv |-> push && push_data.q_w == '0
      && push_data.i_w[WORD_W-1 -: REAL_W] == real_data;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass sample not passed");

  property p_rate;
    @(posedge clk) disable iff (srst)
    push && !bypass |-> gap_ff >= GAP_W'(dec_factor(dec));
  endproperty
  a_rate: assert property (p_rate) else $error("output faster than factor");

  sequence s_flag_in;
    mix_fire && !bypass && overrange_flag_first;
  endsequence
  property p_flag_held;
    @(posedge clk) disable iff (srst)
    s_flag_in |=> flag1_ff && (!push || bypass || push_data.i_w[0]);
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("first flag lost");

  property p_boost;
    @(posedge clk) disable iff (srst)
    push && !bypass && boost_ff && (s5.i[LANE_W-1] == s5.i[LANE_W-2])
      |-> push_data.i_w[WORD_W-1:1] == s5.i[LANE_W-2:IN_SHL-1];
  endproperty
  a_boost: assert property (p_boost) else $error("boost gain not two");

  property p_unity;
    @(posedge clk) disable iff (srst)
    push && !bypass && !boost_ff |-> push_data.q_w[WORD_W-1:1] == s5.q[LANE_W-1:IN_SHL];
  endproperty
  a_unity: assert property (p_unity) else $error("gain not unity");

  property p_strobe;
    @(posedge clk) disable iff (srst)
    push |=> out_valid;
  endproperty
  a_strobe: assert property (p_strobe) else $error("word not offered");
endmodule : ddcdc_chain
`default_nettype wire

// ---- ddcdc_chain_unused_guard.sv ----
`default_nettype none
`default_nettype wire

// ---- ddcdc_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
// *****
// transport layer sink model
// *****
module ddcdc_sink (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire logic                   stall,
  input  wire logic                   out_valid,
  input  wire ddcdc_pkg::ddcdc_word_s out_data,
  output logic                        out_ready,
  output int                          n_words,
  output ddcdc_pkg::ddcdc_word_s      last_word
);
  import ddcdc_pkg::*;
  // random back-pressure, full stall on request
  always_ff @(posedge clk) begin
    out_ready <= !srst && !stall && ($urandom % 4 != 0);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      n_words <= 0;
    end else if (out_valid && out_ready && ce) begin
      n_words   <= n_words + 1;
      last_word <= out_data;
    end
  end
endmodule : ddcdc_sink
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ddcdc_pkg::*;
  logic              clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic [3:0]        pstrb = 4'hf;
  logic              pready, pslverr, err, in_ready, out_valid, out_ready;
  logic              mix_valid = 0, fa = 0, fb = 0, stall = 0, ce_rnd = 0;
  logic [REAL_W-1:0] real_data = '0;
  ddcdc_mix_s        mix_data = '0;
  ddcdc_word_s       out_data, last_word;
  ddcdc_word_s       exp_q[$];
  int                error_cnt = 0, n_tests = 0, n_words, nf1 = 0, nf2 = 0;
  always #5 clk = ~clk;
  // random clock-enable gaps while ce_rnd is set
  always @(posedge clk) ce <= !ce_rnd || ($urandom % 8 != 0);
  ddcdc_chain dut (.clk(clk), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mix_valid(mix_valid), .mix_data(mix_data),
    .real_data(real_data), .overrange_flag_first(fa), .overrange_flag_second(fb),
    .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  ddcdc_sink sink (.clk(clk), .srst(srst), .ce(ce), .stall(stall), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .n_words(n_words), .last_word(last_word));
  // *****
  // checks
  // *****
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // filter taps do not sum to an exact power of two
  task automatic near(input string nm, input int e, input logic signed [31:0] g);
    n_tests++;
    if ((g <= e + 2 && g >= e - 2) !== 1'b1) begin
      error_cnt++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask : near
  always @(posedge clk) begin
    if (out_valid && out_ready && ce) begin
      nf1 += out_data.i_w[0];
      nf2 += out_data.q_w[0];
      if (exp_q.size() > 0) cmp("byp_word", exp_q.pop_front(), out_data);
    end
  end
  // *****
  // drivers
  // *****
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic put(input logic [14:0] x, y, input logic a, b);
    mix_valid <= 1;
    mix_data <= '{x, y};
    real_data <= x[11:0];
    fa <= a;
    fb <= b;
    @(posedge clk);
    while (in_ready !== 1'b1 || ce !== 1'b1) @(posedge clk);
  endtask : put
  task automatic drain();
    mix_valid <= 0;
    ce_rnd <= 0;
    repeat (8) @(posedge clk);
    while (out_valid !== 1'b0) @(posedge clk);
  endtask : drain
  task automatic close_out();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    #500_000;
    error_cnt++;
    close_out();
  end
  // *****
  // scenarios
  // *****
  initial begin
    int m, x, y, g, k, a0, a1;
    void'($urandom(32'hd74837d0));
    repeat (6) @(posedge clk);
    srst <= 0;
    apb(0, REG_CTRL, '0);
    cmp("ctrl_rst", 32'h0000_0000, rd);
    apb(0, 12'h008, '0);
    cmp("unmapped", 32'h0000_0001, {rd[30:0], err});
    // undefined mode value falls to bypass; fifo filled with sink stalled
    stall <= 1;
    apb(1, REG_CTRL, 32'h0000_001f);
    apb(0, REG_STATUS, '0);
    cmp("dec_code", 32'h0000_0000, 32'(rd[2:0]));
    for (k = 0; k < FIFO_DEPTH; k++) begin
      x = $urandom;
      exp_q.push_back({x[11:0], 4'h0, 16'h0000});
      put(15'(x), 15'(x), 0, 0);
    end
    apb(0, REG_STATUS, '0);
    cmp("status_full", 32'h0000_0300, {22'h0, rd[9:0]});
    cmp("in_ready", 32'h0000_0000, 32'(in_ready));
    stall <= 0;
    drain();
    cmp("byp_left", 32'h0000_0000, 32'(exp_q.size()));
    for (m = 1; m <= 4; m++) begin
      g = (m == 2) ? 2 : 1;
      apb(1, REG_CTRL, {23'h0, m == 2, 3'h0, 5'(m)});
      apb(0, REG_STATUS, '0);
      cmp("dec_code", 32'(m), 32'(rd[2:0]));
      x = $urandom_range(8000) - 4000;
      y = (m == 3) ? x : $urandom_range(8000) - 4000;
      k = n_words;
      ce_rnd <= m > 2;
      repeat (2048) put(15'(x), 15'(y), 0, 0);
      drain();
      cmp("n_out", 32'(2048 >> (m + 1)), 32'(n_words - k));
      near("dc_i", x * g, 32'($signed(last_word.i_w[15:1])));
      near("dc_q", y * g, 32'($signed(last_word.q_w[15:1])));
      a0 = nf1;
      a1 = nf2;
      put(15'(x), 15'(y), m[0], !m[0]);
      repeat (2 << m) put(15'(x), 15'(y), 0, 0);
      drain();
      cmp("flags", 32'(m % 2 ? 2 : 1), 32'(2 * (nf1 - a0) + nf2 - a1));
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
